// file: core/dbl_defs.svh
// Constants for the double-buffered converter latch host controller
`ifndef DBL_DEFS_SVH
`define DBL_DEFS_SVH
// Strobe timing
`define DBL_SETUP_NS 16
`define DBL_PULSE_NS 40
`define DBL_HOLD_NS 16
`define DBL_CLK_NS 8
// Cycle counts, least times rounded up
`define DBL_SETUP_CYC ((`DBL_SETUP_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
`define DBL_PULSE_CYC ((`DBL_PULSE_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
`define DBL_HOLD_CYC ((`DBL_HOLD_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
// Data widths and bipolar-zero code
`define DBL_WORD_W 16
`define DBL_BYTE_W 8
`define DBL_SER_BITS 16
`define DBL_BIPOLAR_ZERO 16'h0000
// Command codes
`define DBL_CMD_WORD 3'h0
`define DBL_CMD_BYTES 3'h1
`define DBL_CMD_SERIAL 3'h2
`define DBL_CMD_CLEAR 3'h3
`endif

// file: core/dbl_pkg.sv
// Types for the double-buffered converter latch host controller
package dbl_pkg;
    // Pin group for the converter control lines
    typedef struct packed {
        logic write_strobe_n;
        logic device_select_n;
        logic low_byte_latch_enable_n;
        logic high_byte_latch_enable_n;
        logic output_latch_enable_n;
        logic word_latch_enable_n;
        logic dac_latch_enable_n;
        logic clear_n;
    } dbl_ctl_t;
    // Sequencer states
    typedef enum logic [3:0] {
        DBL_IDLE, DBL_SETUP, DBL_PULSE, DBL_HOLD, DBL_NEXT
    } dbl_state_t;
    // Latch step being written
    typedef enum logic [2:0] {
        DBL_STEP_WORD, DBL_STEP_LOW, DBL_STEP_HIGH, DBL_STEP_SER,
        DBL_STEP_OUT, DBL_STEP_DAC, DBL_STEP_CLR
    } dbl_step_t;
endpackage

// file: core/dbl_host.sv
// Host sequencer that loads a double-buffered 16-bit converter
`timescale 1ns/100ps
// Operation
// - Byte model output latch loads while low
// - Low byte latch enable loads bits seven-zero
// - High byte latch enable loads bits fifteen-eight
// - Both byte enables low selects serial mode
// - Write strobe is active low
// - Word converter latch enable active low
// - Word input latch enable active low
// - Device select qualifies byte-model writes
`include "dbl_defs.svh"
module dbl_host #(
    parameter int WORD_W = `DBL_WORD_W,
    parameter int BYTE_W = `DBL_BYTE_W
) (
    // Clock, reset, enable
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Command port from local logic
    input wire logic cmd_valid_i,
    input wire logic [2:0] cmd_i,
    input wire logic [WORD_W-1:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic done_o,
    // Converter pins
    output dbl_pkg::dbl_ctl_t ctl_o,
    output logic [WORD_W-1:0] word_data_o,
    output logic [BYTE_W-1:0] byte_data_o
);
    localparam logic [3:0] SETUP_C = 4'(`DBL_SETUP_CYC);
    localparam logic [3:0] PULSE_C = 4'(`DBL_PULSE_CYC);
    localparam logic [3:0] HOLD_C = 4'(`DBL_HOLD_CYC);
    localparam logic [4:0] SER_LAST = 5'(`DBL_SER_BITS - 1);

    // Idle level of every control line: all strobes high
    localparam dbl_pkg::dbl_ctl_t CTL_IDLE = 8'hFF;

    // Sequencer state
    dbl_pkg::dbl_state_t state, next_state;
    dbl_pkg::dbl_step_t step, next_step;
    logic [3:0] cnt, next_cnt;
    logic [4:0] bit_idx, next_bit_idx;
    logic [WORD_W-1:0] data, next_data;
    logic [2:0] cmd, next_cmd;
    // Registered pins
    dbl_pkg::dbl_ctl_t next_ctl;
    logic [WORD_W-1:0] next_word;
    logic [BYTE_W-1:0] next_byte;
    logic next_ready, next_done;

    // Enable pattern for one step; strobe handled separately
    function automatic dbl_pkg::dbl_ctl_t step_ctl(dbl_pkg::dbl_step_t s);
        dbl_pkg::dbl_ctl_t c;
        c = CTL_IDLE;
        case (s)
            dbl_pkg::DBL_STEP_WORD: begin
                c.word_latch_enable_n = 1'b0;
            end
            dbl_pkg::DBL_STEP_LOW: begin
                c.device_select_n = 1'b0;
                c.low_byte_latch_enable_n = 1'b0;
            end
            dbl_pkg::DBL_STEP_HIGH: begin
                c.device_select_n = 1'b0;
                c.high_byte_latch_enable_n = 1'b0;
            end
            dbl_pkg::DBL_STEP_SER: begin
                c.device_select_n = 1'b0;
                c.low_byte_latch_enable_n = 1'b0;
                c.high_byte_latch_enable_n = 1'b0;
            end
            dbl_pkg::DBL_STEP_OUT: begin
                c.device_select_n = 1'b0;
                c.output_latch_enable_n = 1'b0;
            end
            dbl_pkg::DBL_STEP_DAC: begin
                c.dac_latch_enable_n = 1'b0;
            end
            dbl_pkg::DBL_STEP_CLR: begin
                c.clear_n = 1'b0;
            end
            default: begin
                c = CTL_IDLE;
            end
        endcase
        return c;
    endfunction

    // Next step after the current one completes; the OUT, DAC or CLR step ends the job
    function automatic dbl_pkg::dbl_step_t follow(dbl_pkg::dbl_step_t s,
                                                  logic [2:0] k);
        case (s)
            dbl_pkg::DBL_STEP_WORD: follow = dbl_pkg::DBL_STEP_DAC;
            dbl_pkg::DBL_STEP_HIGH: follow = dbl_pkg::DBL_STEP_LOW;
            dbl_pkg::DBL_STEP_LOW: follow = dbl_pkg::DBL_STEP_OUT;
            dbl_pkg::DBL_STEP_SER: follow = dbl_pkg::DBL_STEP_OUT;
            default: follow = dbl_pkg::DBL_STEP_CLR;
        endcase
        if (k == `DBL_CMD_CLEAR) begin
            follow = dbl_pkg::DBL_STEP_CLR;
        end
    endfunction

    // Next-state logic for the write sequencer
    always_comb begin
        next_state = state;
        next_step = step;
        next_cnt = cnt;
        next_bit_idx = bit_idx;
        next_data = data;
        next_cmd = cmd;
        next_ctl = ctl_o;
        next_word = word_data_o;
        next_byte = byte_data_o;
        next_ready = 1'b0;
        next_done = 1'b0;
        case (state)
            dbl_pkg::DBL_IDLE: begin
                next_ctl = CTL_IDLE;
                next_ready = 1'b1;
                if (cmd_valid_i && cmd_ready_o) begin
                    next_ready = 1'b0;
                    next_data = cmd_data_i;
                    next_cmd = cmd_i;
                    next_bit_idx = 5'h00;
                    next_cnt = SETUP_C;
                    next_state = dbl_pkg::DBL_SETUP;
                    case (cmd_i)
                        `DBL_CMD_BYTES: next_step = dbl_pkg::DBL_STEP_HIGH;
                        `DBL_CMD_SERIAL: next_step = dbl_pkg::DBL_STEP_SER;
                        `DBL_CMD_CLEAR: next_step = dbl_pkg::DBL_STEP_CLR;
                        default: next_step = dbl_pkg::DBL_STEP_WORD;
                    endcase
                end
            end
            dbl_pkg::DBL_SETUP: begin
                // Enables and data settle before the strobe falls
                next_ctl = step_ctl(step);
                next_word = data;
                next_byte = data[BYTE_W-1:0];
                if (step == dbl_pkg::DBL_STEP_HIGH) begin
                    next_byte = data[WORD_W-1:BYTE_W];
                end
                if (step == dbl_pkg::DBL_STEP_SER) begin
                    // Only pin zero matters; MSB first
                    next_byte = {{(BYTE_W-1){1'b0}}, data[WORD_W-1]};
                end
                next_cnt = cnt - 4'h1;
                if (cnt <= 4'h1) begin
                    next_cnt = PULSE_C;
                    next_state = dbl_pkg::DBL_PULSE;
                end
            end
            dbl_pkg::DBL_PULSE: begin
                // Latch transparent for the whole low strobe
                next_ctl.write_strobe_n = 1'b0;
                next_cnt = cnt - 4'h1;
                if (cnt <= 4'h1) begin
                    // Last low edge; extra count covers the rising edge
                    next_cnt = HOLD_C + 4'h1;
                    next_state = dbl_pkg::DBL_HOLD;
                end
            end
            dbl_pkg::DBL_HOLD: begin
                // Strobe rises first, data and enables held after it
                next_ctl.write_strobe_n = 1'b1;
                next_cnt = cnt - 4'h1;
                if (cnt <= 4'h1) begin
                    next_ctl = CTL_IDLE;
                    next_state = dbl_pkg::DBL_NEXT;
                end
            end
            dbl_pkg::DBL_NEXT: begin
                next_cnt = SETUP_C;
                next_state = dbl_pkg::DBL_SETUP;
                if (step == dbl_pkg::DBL_STEP_SER && bit_idx != SER_LAST) begin
                    next_bit_idx = bit_idx + 5'h01;
                    next_data = {data[WORD_W-2:0], 1'b0};
                end else if (step == dbl_pkg::DBL_STEP_CLR ||
                             step == dbl_pkg::DBL_STEP_OUT ||
                             step == dbl_pkg::DBL_STEP_DAC) begin
                    // Last latch of the job written
                    next_done = 1'b1;
                    next_ready = 1'b1;
                    next_state = dbl_pkg::DBL_IDLE;
                end else begin
                    next_step = follow(step, cmd);
                end
            end
            default: begin
                next_state = dbl_pkg::DBL_IDLE;
            end
        endcase
    end

    // Registers; reset loads bipolar-zero data, clear step drives the command data
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            state <= dbl_pkg::DBL_IDLE;
            step <= dbl_pkg::DBL_STEP_WORD;
            cnt <= 4'h0;
            bit_idx <= 5'h00;
            data <= `DBL_BIPOLAR_ZERO;
            cmd <= 3'h0;
            ctl_o <= CTL_IDLE;
            word_data_o <= '0;
            byte_data_o <= '0;
            cmd_ready_o <= 1'b0;
            done_o <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            step <= next_step;
            cnt <= next_cnt;
            bit_idx <= next_bit_idx;
            data <= next_data;
            cmd <= next_cmd;
            ctl_o <= next_ctl;
            word_data_o <= next_word;
            byte_data_o <= next_byte;
            cmd_ready_o <= next_ready;
            done_o <= next_done;
        end
    end
endmodule

// file: verif/dbl_host_assertions.sv
// Port checker for the converter latch host
`timescale 1ns/100ps
module dbl_chk (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Watched outputs
    input wire logic cmd_ready_o,
    input wire dbl_pkg::dbl_ctl_t ctl_o,
    input wire logic [15:0] word_data_o,
    input wire logic [7:0] byte_data_o
);
    logic byte_en; // Some byte-model enable low
    logic word_en; // Some word-model enable low
    logic both_en; // Both byte enables low
    assign byte_en = !(ctl_o.low_byte_latch_enable_n
        && ctl_o.high_byte_latch_enable_n && ctl_o.output_latch_enable_n);
    assign word_en = !(ctl_o.word_latch_enable_n && ctl_o.dac_latch_enable_n);
    assign both_en = !ctl_o.low_byte_latch_enable_n
        && !ctl_o.high_byte_latch_enable_n;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    strobe_width_a: assert property ($fell(ctl_o.write_strobe_n) |->
        !ctl_o.write_strobe_n [*5] ##1 ctl_o.write_strobe_n)
        else $error("strobe width wrong");
    strobe_cause_a: assert property (!ctl_o.write_strobe_n |->
        !(&ctl_o[5:0])) else $error("strobe with no enable");
    byte_select_a: assert property (byte_en |->
        !ctl_o.device_select_n) else $error("byte step unselected");
    word_select_a: assert property (word_en |->
        ctl_o.device_select_n && !byte_en) else $error("word step mixed");
    enable_setup_a: assert property ($fell(ctl_o.write_strobe_n) |->
        $past(ctl_o[5:1], 2) == ctl_o[5:1]) else $error("enable setup");
    enable_hold_a: assert property ($rose(ctl_o.write_strobe_n) |=>
        $stable(ctl_o[5:1])) else $error("enable hold");
    data_hold_a: assert property (!ctl_o.write_strobe_n |=>
        $stable(word_data_o) && $stable(byte_data_o))
        else $error("data moved under strobe");
    serial_mode_a: assert property (both_en |->
        ctl_o.output_latch_enable_n && !word_en)
        else $error("serial mixed with other enable");
    busy_strobe_a: assert property (!ctl_o.write_strobe_n |->
        !cmd_ready_o) else $error("ready during strobe");
endmodule
bind dbl_host dbl_chk chk_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .cmd_ready_o(cmd_ready_o), .ctl_o(ctl_o), .word_data_o(word_data_o),
    .byte_data_o(byte_data_o));

// file: verif/dbl_dev_model.sv
// Behavioural model of the double-buffered converter latches
`timescale 1ns/100ps
`include "dbl_defs.svh"
module dbl_dev_model (
    // Pins from the host
    input wire dbl_pkg::dbl_ctl_t ctl_i,
    input wire logic [15:0] word_i,
    input wire logic [7:0] byte_i,
    // Latch contents
    output logic [15:0] in_o,
    output logic [15:0] out_o
);
    logic [1:0] sel; // High and low byte enables
    assign sel = {ctl_i.high_byte_latch_enable_n, ctl_i.low_byte_latch_enable_n};
    // Latches close as the active-low strobe rises; data still held then
    always @(posedge ctl_i.write_strobe_n) begin
        if (!ctl_i.clear_n) begin
            in_o <= 16'h0000;
            out_o <= `DBL_BIPOLAR_ZERO;
        end else if (!ctl_i.word_latch_enable_n) begin
            in_o <= word_i;
        end else if (!ctl_i.dac_latch_enable_n) begin
            out_o <= in_o;
        end else if (!ctl_i.device_select_n) begin
            case (sel)
                2'b00: in_o <= {in_o[14:0], byte_i[0]};
                2'b01: in_o[15:8] <= byte_i;
                2'b10: in_o[7:0] <= byte_i;
                default: if (!ctl_i.output_latch_enable_n) out_o <= in_o;
            endcase
        end
    end
endmodule

// file: verif/testbench.sv
// Self-checking bench for the converter latch host
`timescale 1ns/100ps
`include "dbl_defs.svh"
module testbench;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_i = 1'b1;
    logic cmd_valid_i = 1'b0;
    logic [2:0] cmd_i = 3'h0;
    logic [15:0] cmd_data_i = 16'h0000;
    logic cmd_ready_o;
    logic done_o;
    dbl_pkg::dbl_ctl_t ctl_o;
    logic [15:0] word_data_o;
    logic [15:0] in_q; // Model input register
    logic [15:0] out_q; // Model converter register
    logic [7:0] byte_data_o;
    int num_errors = 0;
    int tests_run = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    dbl_host dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_data_i(cmd_data_i),
        .cmd_ready_o(cmd_ready_o), .done_o(done_o), .ctl_o(ctl_o),
        .word_data_o(word_data_o), .byte_data_o(byte_data_o));
    dbl_dev_model model_u (.ctl_i(ctl_o), .word_i(word_data_o),
        .byte_i(byte_data_o), .in_o(in_q), .out_o(out_q));
    task automatic wrap_up();
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One job: wait ready, offer at falling edge, wait bounded for done
    task automatic run(input logic [2:0] c, input logic [15:0] d);
        int n;
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 100) begin
            @(negedge sys_clk_i);
            n++;
        end
        cmd_i = c;
        cmd_data_i = d;
        cmd_valid_i = 1'b1;
        @(negedge sys_clk_i);
        cmd_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 400) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk(16'(n >= 400), 16'h0000);
    endtask
    task automatic t_word();
        run(`DBL_CMD_WORD, 16'hA5C3);
        chk(out_q, 16'hA5C3);
    endtask
    task automatic t_bytes();
        run(`DBL_CMD_BYTES, 16'h3C96);
        chk(out_q, 16'h3C96);
    endtask
    task automatic t_serial();
        run(`DBL_CMD_SERIAL, 16'h8E71);
        chk(out_q, 16'h8E71);
    endtask
    task automatic t_clear();
        run(`DBL_CMD_CLEAR, 16'hFFFF);
        chk(in_q, 16'h0000);
        chk(out_q, `DBL_BIPOLAR_ZERO);
    endtask
    // Enable low: a command offered meanwhile must not start a job
    task automatic t_freeze();
        ce_i = 1'b0;
        cmd_i = `DBL_CMD_WORD;
        cmd_data_i = 16'h1234;
        cmd_valid_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        cmd_valid_i = 1'b0;
        ce_i = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        chk(16'(ctl_o), 16'h00FF);
        chk(out_q, `DBL_BIPOLAR_ZERO);
    endtask
    initial begin
        repeat (4) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        chk(16'(ctl_o), 16'h00FF);
        t_word();
        t_bytes();
        t_serial();
        t_clear();
        t_freeze();
        wrap_up();
    end
    // Whole run needs about three hundred cycles
    initial begin
        #40000;
        num_errors++;
        wrap_up();
    end
endmodule
